// *** hw/nvac_pkg.sv ***
package nvac_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_UNLOCK_KEY = 8'h0c;
    localparam logic [7:0] OFS_DATA_LOW = 8'h10;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h14;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int CTL_FLASH_SEL = 7;
    localparam int CTL_CONFIG_SEL = 6;
    localparam int CTL_LATCH_ONLY = 5;
    localparam int CTL_ERASE_SEL = 4;
    localparam int CTL_FAULT = 3;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_WRITE = 1;
    localparam int CTL_READ = 0;

    // ----------------------------------------
    // reset values and fixed patterns
    // ----------------------------------------
    localparam logic [7:0] RST_ADDR_LOW = 8'h00;
    localparam logic [6:0] RST_ADDR_HIGH = 7'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [13:0] RST_WORD = 14'h0000;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // ----------------------------------------
    // configuration space map (full 15-bit address)
    // ----------------------------------------
    localparam logic [14:0] CFG_USER_ID_FIRST = 15'h0000;
    localparam logic [14:0] CFG_USER_ID_LAST = 15'h0003;
    localparam logic [14:0] CFG_DEVICE_ID = 15'h0006;
    localparam logic [14:0] CFG_WORD_FIRST = 15'h0007;
    localparam logic [14:0] CFG_WORD_LAST = 15'h0008;

    // ----------------------------------------
    // memory space codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        NVAC_SPACE_EEPROM = 2'b00,
        NVAC_SPACE_FLASH = 2'b01,
        NVAC_SPACE_CONFIG = 2'b10
    } nvac_space_t;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int ERASE_TIME_NS = 2000000;
    localparam int PROGRAM_TIME_NS = 2000000;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : nvac_pkg

// *** hw/nvac_top.sv ***
`timescale 1ns/1ps
// How it works
// R1 - low address register supplies address bits 7 to 0
// R2 - high register low seven bits give address 14 to 8; bit 7 reads one
// R3 - control bit 7 one selects program flash, zero selects data eeprom
// R4 - control bit 6 one selects configuration and id space instead
// R5 - flash/config with latch-only set: write command only loads write latches
// R6 - flash/config with latch-only clear: load latches, then program all latched data
// R7 - eeprom selected: latch-only ignored, write command starts eeprom write directly
// R8 - flash/config erase bit selects erase; hardware clears it after erase ends
// R9 - eeprom selected: erase bit ignored, each write does erase then write
// R10 - fault flag bit 3 set on write attempts; normal completion clears it
// R11 - program or erase starts only while permit bit 2 is one
// R12 - write bit 1 set-only starts self-timed cycle; hardware clears at end
// R13 - read bit 0 set-only; read takes one cycle, hardware clears it
// R14 - key register must see 55h then aah before write is accepted
// R15 - key register is write-only with no readable storage
// R16 - write without unlock pair or permit starts no cycle
// R17 - cpu stalled while flash or config write or erase runs
// R18 - data pair holds 14 bits; high register top two bits read zero
// R19 - user ids read-write; device id and config words read-only
// R20 - config read outside accessible set clears both data registers
module nvac_top #(
    parameter int ERASE_CYCLES = nvac_pkg::ERASE_CYCLES,
    parameter int PROGRAM_CYCLES = nvac_pkg::PROGRAM_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // nonvolatile array
    output logic [14:0] mem_addr,
    output logic [1:0] mem_space,
    output logic [13:0] mem_wdata,
    output logic mem_read,
    input wire logic [13:0] mem_rdata,
    output logic mem_latch_load,
    output logic mem_erase_active,
    output logic mem_program_active,
    // core
    output logic cpu_stall
);

    // ----------------------------------------
    // types and functions
    // ----------------------------------------
    typedef enum logic [1:0] {
        NVAC_ST_IDLE = 2'b00,
        NVAC_ST_ERASE = 2'b01,
        NVAC_ST_PROGRAM = 2'b10,
        NVAC_ST_LATCH = 2'b11
    } nvac_state_t;

    function automatic logic in_range(input logic [14:0] a, input logic [14:0] lo,
                                      input logic [14:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] addr_low_reg;
    logic [6:0] addr_high_reg;
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] data_low_reg;
    logic [5:0] data_high_reg;
    logic [1:0] key_stage_reg;
    nvac_state_t state_reg;
    logic [15:0] timer_reg;
    logic read_phase_reg;
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic latch_pulse_reg;
    logic erase_out_reg;
    logic program_out_reg;
    logic read_out_reg;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire ap_take = hsel && htrans[1] && hready;
    wire wr_any = dp_valid_reg && dp_write_reg;
    wire wr_addr_low = wr_any && (dp_addr_reg == nvac_pkg::OFS_ADDR_LOW);
    wire wr_addr_high = wr_any && (dp_addr_reg == nvac_pkg::OFS_ADDR_HIGH);
    wire wr_control = wr_any && (dp_addr_reg == nvac_pkg::OFS_CONTROL);
    wire wr_key = wr_any && (dp_addr_reg == nvac_pkg::OFS_UNLOCK_KEY);
    wire wr_data_low = wr_any && (dp_addr_reg == nvac_pkg::OFS_DATA_LOW);
    wire wr_data_high = wr_any && (dp_addr_reg == nvac_pkg::OFS_DATA_HIGH);
    wire [7:0] wbyte = hwdata[7:0];

    // ----------------------------------------
    // addressing and space
    // ----------------------------------------
    // R1 low address bits
    wire [14:0] full_addr = {addr_high_reg, addr_low_reg};
    wire flash_sel = control_reg[nvac_pkg::CTL_FLASH_SEL];
    wire config_sel = control_reg[nvac_pkg::CTL_CONFIG_SEL];
    wire latch_only = control_reg[nvac_pkg::CTL_LATCH_ONLY];
    wire erase_sel = control_reg[nvac_pkg::CTL_ERASE_SEL];
    wire permit = control_reg[nvac_pkg::CTL_PERMIT];
    wire busy = (state_reg != NVAC_ST_IDLE);
    // R3 flash or eeprom, R4 config overrides
    wire [1:0] space_sel = config_sel ? nvac_pkg::NVAC_SPACE_CONFIG :
                           flash_sel ? nvac_pkg::NVAC_SPACE_FLASH :
                           nvac_pkg::NVAC_SPACE_EEPROM;
    wire eeprom_sel = !config_sel && !flash_sel;
    // R19 config access map
    wire cfg_user = in_range(full_addr, nvac_pkg::CFG_USER_ID_FIRST,
                             nvac_pkg::CFG_USER_ID_LAST);
    wire cfg_readable = cfg_user || (full_addr == nvac_pkg::CFG_DEVICE_ID) ||
                        in_range(full_addr, nvac_pkg::CFG_WORD_FIRST,
                                 nvac_pkg::CFG_WORD_LAST);
    // R3 R4 space of a start comes from the control write itself
    wire start_eeprom = !wbyte[nvac_pkg::CTL_CONFIG_SEL] && !wbyte[nvac_pkg::CTL_FLASH_SEL];
    wire target_writable = !wbyte[nvac_pkg::CTL_CONFIG_SEL] || cfg_user;

    // ----------------------------------------
    // write start decision
    // ----------------------------------------
    wire wr_set_try = wr_control && wbyte[nvac_pkg::CTL_WRITE] && !busy;
    // R14 key order, R11 permit, R16 refuse otherwise
    wire start_ok = wr_set_try && (key_stage_reg == 2'd2) &&
                    wbyte[nvac_pkg::CTL_PERMIT] && target_writable;
    wire rd_set_try = wr_control && wbyte[nvac_pkg::CTL_READ] && !busy;
    wire timer_done = (timer_reg == 16'h0000);
    wire op_end = (state_reg == NVAC_ST_LATCH) ||
                  (state_reg == NVAC_ST_PROGRAM && timer_done) ||
                  (state_reg == NVAC_ST_ERASE && timer_done && !eeprom_sel);
    wire erase_end = (state_reg == NVAC_ST_ERASE) && timer_done;

    // ----------------------------------------
    // control register next value
    // ----------------------------------------
    always_comb begin
        control_next = control_reg;
        if (wr_control && !busy) begin
            control_next[7:4] = wbyte[7:4];
            control_next[nvac_pkg::CTL_PERMIT] = wbyte[nvac_pkg::CTL_PERMIT];
            control_next[nvac_pkg::CTL_FAULT] = wbyte[nvac_pkg::CTL_FAULT];
        end
        // R13 set-only read bit, one-cycle read
        if (read_phase_reg) begin
            control_next[nvac_pkg::CTL_READ] = 1'b0;
        end
        if (rd_set_try) begin
            control_next[nvac_pkg::CTL_READ] = 1'b1;
        end
        // R12 hardware clears write bit at end
        if (op_end) begin
            control_next[nvac_pkg::CTL_WRITE] = 1'b0;
            control_next[nvac_pkg::CTL_FAULT] = 1'b0;
        end
        // R8 hardware clears erase bit after erase
        if (erase_end && !eeprom_sel) begin
            control_next[nvac_pkg::CTL_ERASE_SEL] = 1'b0;
        end
        // R12 write bit only set by software
        if (start_ok) begin
            control_next[nvac_pkg::CTL_WRITE] = 1'b1;
        end
        // R10 fault flag on set attempt, set wins
        if (wr_set_try) begin
            control_next[nvac_pkg::CTL_FAULT] = 1'b1;
        end
    end

    // ----------------------------------------
    // bus data phase capture
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else if (hready) begin
            dp_valid_reg <= ap_take;
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr[7:0];
        end
    end

    // ----------------------------------------
    // address, control and key registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_low_reg <= nvac_pkg::RST_ADDR_LOW;
            addr_high_reg <= nvac_pkg::RST_ADDR_HIGH;
            control_reg <= nvac_pkg::RST_CONTROL;
        end else begin
            control_reg <= control_next;
            if (wr_addr_low && !busy) begin
                addr_low_reg <= wbyte;
            end
            // R2 seven implemented high bits
            if (wr_addr_high && !busy) begin
                addr_high_reg <= wbyte[6:0];
            end
        end
    end

    // R14 unlock key sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_stage_reg <= 2'd0;
        end else if (wr_key) begin
            if (wbyte == nvac_pkg::KEY_FIRST) begin
                key_stage_reg <= 2'd1;
            end else if (wbyte == nvac_pkg::KEY_SECOND && key_stage_reg == 2'd1) begin
                key_stage_reg <= 2'd2;
            end else begin
                key_stage_reg <= 2'd0;
            end
        end else if (wr_control || (wr_any && key_stage_reg == 2'd1)) begin
            key_stage_reg <= 2'd0;
        end
    end

    // ----------------------------------------
    // data register pair
    // ----------------------------------------
    // R18 fourteen-bit word, R20 cleared on bad config read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_low_reg <= nvac_pkg::RST_WORD[7:0];
            data_high_reg <= nvac_pkg::RST_WORD[13:8];
        end else if (read_phase_reg) begin
            if (config_sel && !cfg_readable) begin
                data_low_reg <= nvac_pkg::RST_WORD[7:0];
                data_high_reg <= nvac_pkg::RST_WORD[13:8];
            end else begin
                data_low_reg <= mem_rdata[7:0];
                data_high_reg <= mem_rdata[13:8];
            end
        end else if (!busy) begin
            if (wr_data_low) begin
                data_low_reg <= wbyte;
            end
            if (wr_data_high) begin
                data_high_reg <= wbyte[5:0];
            end
        end
    end

    // ----------------------------------------
    // operation sequencer
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= NVAC_ST_IDLE;
            timer_reg <= 16'h0000;
            read_phase_reg <= 1'b0;
        end else begin
            read_phase_reg <= rd_set_try;
            case (state_reg)
                NVAC_ST_IDLE: begin
                    if (start_ok) begin
                        if (!start_eeprom && wbyte[nvac_pkg::CTL_LATCH_ONLY]
                            && !wbyte[nvac_pkg::CTL_ERASE_SEL]) begin
                            // R5 latch-only load
                            state_reg <= NVAC_ST_LATCH;
                        end else if (start_eeprom || wbyte[nvac_pkg::CTL_ERASE_SEL]) begin
                            // R9 eeprom erases first, R8 flash erase
                            state_reg <= NVAC_ST_ERASE;
                            timer_reg <= 16'(ERASE_CYCLES - 1);
                        end else begin
                            // R6 load then program latches
                            state_reg <= NVAC_ST_PROGRAM;
                            timer_reg <= 16'(PROGRAM_CYCLES - 1);
                        end
                    end
                end
                NVAC_ST_ERASE: begin
                    if (!timer_done) begin
                        timer_reg <= timer_reg - 16'h0001;
                    end else if (eeprom_sel) begin
                        // R7 eeprom write follows its erase
                        state_reg <= NVAC_ST_PROGRAM;
                        timer_reg <= 16'(PROGRAM_CYCLES - 1);
                    end else begin
                        state_reg <= NVAC_ST_IDLE;
                    end
                end
                NVAC_ST_PROGRAM: begin
                    if (!timer_done) begin
                        timer_reg <= timer_reg - 16'h0001;
                    end else begin
                        state_reg <= NVAC_ST_IDLE;
                    end
                end
                NVAC_ST_LATCH: begin
                    state_reg <= NVAC_ST_IDLE;
                end
                default: begin
                    state_reg <= NVAC_ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // array strobes
    // ----------------------------------------
    // R6 latch loaded at start of any flash program
    wire latch_next = start_ok && !start_eeprom && !wbyte[nvac_pkg::CTL_ERASE_SEL];
    wire erase_next = (state_reg == NVAC_ST_ERASE && !timer_done) ||
                      (start_ok && (start_eeprom || wbyte[nvac_pkg::CTL_ERASE_SEL]));
    wire program_next = (state_reg == NVAC_ST_PROGRAM && !timer_done) ||
                        (erase_end && eeprom_sel) ||
                        (start_ok && !start_eeprom && !wbyte[nvac_pkg::CTL_LATCH_ONLY]
                         && !wbyte[nvac_pkg::CTL_ERASE_SEL]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_pulse_reg <= 1'b0;
            erase_out_reg <= 1'b0;
            program_out_reg <= 1'b0;
            read_out_reg <= 1'b0;
        end else begin
            latch_pulse_reg <= latch_next;
            erase_out_reg <= erase_next;
            program_out_reg <= program_next;
            read_out_reg <= rd_set_try;
        end
    end

    assign mem_addr = full_addr;
    assign mem_space = space_sel;
    assign mem_wdata = {data_high_reg, data_low_reg};
    assign mem_read = read_out_reg;
    assign mem_latch_load = latch_pulse_reg;
    assign mem_erase_active = erase_out_reg;
    assign mem_program_active = program_out_reg;
    // R17 stall core during flash or config cycles
    assign cpu_stall = busy && !eeprom_sel;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // R15 key register reads zero, R2 top bit reads one
    wire [7:0] rd_byte = (dp_addr_reg == nvac_pkg::OFS_ADDR_LOW) ? addr_low_reg :
                         (dp_addr_reg == nvac_pkg::OFS_ADDR_HIGH) ? {1'b1, addr_high_reg} :
                         (dp_addr_reg == nvac_pkg::OFS_CONTROL) ? control_reg :
                         (dp_addr_reg == nvac_pkg::OFS_DATA_LOW) ? data_low_reg :
                         (dp_addr_reg == nvac_pkg::OFS_DATA_HIGH) ? {2'b00, data_high_reg} :
                         8'h00;
    assign hrdata = (dp_valid_reg && !dp_write_reg) ? {24'h000000, rd_byte} : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule : nvac_top

// *** dv/nvac_checker.sv ***
`timescale 1ns/1ps
module nvac_checker #(
    parameter int ERASE_CYCLES = 5,
    parameter int PROGRAM_CYCLES = 5
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // array and core
    input wire logic [14:0] mem_addr,
    input wire logic [1:0] mem_space,
    input wire logic [13:0] mem_wdata,
    input wire logic mem_read,
    input wire logic [13:0] mem_rdata,
    input wire logic mem_latch_load,
    input wire logic mem_erase_active,
    input wire logic mem_program_active,
    input wire logic cpu_stall
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    int er_cnt;
    int pg_cnt;
    logic busy;
    logic ctl_wr;
    logic ee_sel;
    assign busy = cpu_stall | mem_erase_active | mem_program_active;
    assign ctl_wr = hsel & htrans[1] & hready & hwrite & (haddr[7:0] == nvac_pkg::OFS_CONTROL);
    assign ee_sel = (mem_space == nvac_pkg::NVAC_SPACE_EEPROM);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            er_cnt <= 0;
            pg_cnt <= 0;
        end else begin
            er_cnt <= mem_erase_active ? er_cnt + 1 : 0;
            pg_cnt <= mem_program_active ? pg_cnt + 1 : 0;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_read_req;
        !busy && ctl_wr ##1 hwdata[nvac_pkg::CTL_READ];
    endsequence
    sequence s_bad_start;
        !busy && ctl_wr ##1 (hwdata[nvac_pkg::CTL_WRITE] && !hwdata[nvac_pkg::CTL_PERMIT]);
    endsequence
    AST_READ_PULSE: assert property (s_read_req |=> mem_read ##1 !mem_read)
        else $error("read strobe not a single cycle after read request");
    AST_NO_PERMIT: assert property (s_bad_start |=> (!busy && !mem_latch_load) [*3])
        else $error("operation started without permit");
    AST_LATCH_PULSE: assert property ($rose(mem_latch_load) |=> !mem_latch_load)
        else $error("latch load longer than one cycle");
    AST_ERASE_LEN: assert property ($fell(mem_erase_active) |-> er_cnt == ERASE_CYCLES)
        else $error("erase interval length wrong");
    AST_PROG_LEN: assert property ($fell(mem_program_active) |-> pg_cnt == PROGRAM_CYCLES)
        else $error("program interval length wrong");
    AST_EE_ORDER: assert property ($fell(mem_erase_active) && ee_sel |-> ##[0:2] mem_program_active)
        else $error("eeprom erase not followed by write");
    AST_FLASH_STALL: assert property ((mem_erase_active || mem_program_active) && !ee_sel |-> cpu_stall)
        else $error("cpu not stalled during flash operation");
    AST_EE_NO_STALL: assert property ((mem_erase_active || mem_program_active) && ee_sel |-> !cpu_stall)
        else $error("cpu stalled during eeprom operation");
endmodule : nvac_checker

bind nvac_top nvac_checker #(.ERASE_CYCLES(ERASE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .mem_addr(mem_addr), .mem_space(mem_space),
    .mem_wdata(mem_wdata), .mem_read(mem_read), .mem_rdata(mem_rdata),
    .mem_latch_load(mem_latch_load), .mem_erase_active(mem_erase_active),
    .mem_program_active(mem_program_active), .cpu_stall(cpu_stall)
);

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, dph;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, mem_space;
    logic [2:0] hsize;
    logic mem_read, mem_latch_load, mem_erase_active, mem_program_active, cpu_stall;
    logic [14:0] mem_addr;
    logic [13:0] mem_wdata, mem_rdata, md;
    logic [7:0] hi, lo;
    logic [31:0] expq[$];
    logic [16:0] addq[$];
    int err_count;
    int n_compared;
    // read table: control, low address, space, cleared flag
    logic [31:0] rtab[4] = '{32'h81000100, 32'h01000000, 32'h41060200, 32'h41050201};
    // write table: key order, control, low address, final control
    logic [31:0] wtab[10] = '{32'h01860084, 32'h0086008c, 32'h0286008c, 32'h01820088,
        32'h01960084, 32'h01060004, 32'h01360034, 32'h01a600a4, 32'h0146074c, 32'h01460144};

    nvac_top #(.ERASE_CYCLES(5), .PROGRAM_CYCLES(5)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_addr(mem_addr),
        .mem_space(mem_space), .mem_wdata(mem_wdata), .mem_read(mem_read),
        .mem_rdata(mem_rdata), .mem_latch_load(mem_latch_load),
        .mem_erase_active(mem_erase_active), .mem_program_active(mem_program_active),
        .cpu_stall(cpu_stall)
    );

    always #50 hclk = ~hclk;
    assign hready = hreadyout;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task stop_test;
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        logic [31:0] rnd;
        rnd = $urandom;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {rnd[31:8], d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : xfer

    task wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        xfer(a, 1'b0, 8'h00);
    endtask : rd

    task wait_done;
        int idle;
        idle = 0;
        for (int i = 0; i < 100 && idle < 3; i++) begin
            @(posedge hclk);
            idle = ((cpu_stall | mem_erase_active | mem_program_active) === 1'b1) ? 0 : idle + 1;
        end
    endtask : wait_done

    // ----------------------------------------
    // output monitor
    // ----------------------------------------
    always @(posedge hclk) begin
        if (dph && hreadyout) begin
            check(hrdata, expq.pop_front());
        end
        if (mem_read === 1'b1) begin
            check({15'h0000, mem_space, mem_addr}, {15'h0000, addq.pop_front()});
        end
        dph <= hsel & htrans[1] & ~hwrite & hready;
    end

    initial begin
        repeat (3000) @(posedge hclk);
        err_count++;
        stop_test;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hea73));
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        mem_rdata = 14'h0000;
        dph = 1'b0;
        err_count = 0;
        n_compared = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(nvac_pkg::OFS_ADDR_LOW, 32'h00000000);
        rd(nvac_pkg::OFS_ADDR_HIGH, 32'h00000080);
        rd(nvac_pkg::OFS_CONTROL, 32'h00000000);
        rd(8'h20, 32'h00000000);
        hi = 8'($urandom);
        lo = 8'($urandom);
        wr(nvac_pkg::OFS_ADDR_HIGH, hi);
        rd(nvac_pkg::OFS_ADDR_HIGH, {24'h000000, 1'b1, hi[6:0]});
        wr(nvac_pkg::OFS_DATA_HIGH, hi);
        wr(nvac_pkg::OFS_DATA_LOW, lo);
        rd(nvac_pkg::OFS_DATA_HIGH, {26'h0000000, hi[5:0]});
        rd(nvac_pkg::OFS_DATA_LOW, {24'h000000, lo});
        check({18'h0, mem_wdata}, {18'h0, hi[5:0], lo});
        wr(nvac_pkg::OFS_UNLOCK_KEY, nvac_pkg::KEY_FIRST);
        rd(nvac_pkg::OFS_UNLOCK_KEY, 32'h00000000);
        foreach (rtab[i]) begin
            hi = rtab[i][30] ? 8'h00 : 8'($urandom);
            lo = rtab[i][30] ? rtab[i][23:16] : 8'($urandom);
            md = 14'($urandom);
            mem_rdata <= md;
            wr(nvac_pkg::OFS_ADDR_HIGH, hi);
            wr(nvac_pkg::OFS_ADDR_LOW, lo);
            addq.push_back({rtab[i][9:8], hi[6:0], lo});
            wr(nvac_pkg::OFS_CONTROL, rtab[i][31:24]);
            rd(nvac_pkg::OFS_DATA_LOW, rtab[i][0] ? 32'h0 : {24'h0, md[7:0]});
            rd(nvac_pkg::OFS_DATA_HIGH, rtab[i][0] ? 32'h0 : {26'h0, md[13:8]});
            rd(nvac_pkg::OFS_CONTROL, {24'h0, rtab[i][31:25], 1'b0});
        end
        foreach (wtab[i]) begin
            wr(nvac_pkg::OFS_ADDR_HIGH, 8'h00);
            wr(nvac_pkg::OFS_ADDR_LOW, wtab[i][15:8]);
            if (wtab[i][24]) begin
                wr(nvac_pkg::OFS_UNLOCK_KEY, nvac_pkg::KEY_FIRST);
                wr(nvac_pkg::OFS_UNLOCK_KEY, nvac_pkg::KEY_SECOND);
            end
            if (wtab[i][25]) begin
                wr(nvac_pkg::OFS_UNLOCK_KEY, nvac_pkg::KEY_SECOND);
                wr(nvac_pkg::OFS_UNLOCK_KEY, nvac_pkg::KEY_FIRST);
            end
            wr(nvac_pkg::OFS_CONTROL, wtab[i][23:16]);
            if (i == 0) begin
                rd(nvac_pkg::OFS_CONTROL, 32'h0000008e);
            end
            wait_done;
            rd(nvac_pkg::OFS_CONTROL, {24'h0, wtab[i][7:0]});
            wr(nvac_pkg::OFS_CONTROL, 8'h00);
        end
        repeat (2) @(posedge hclk);
        stop_test;
    end
endmodule : tb
